// >>> logic/wdtfs_top.sv
// watchdog timer with two-write feed sequence, fuse enabled
// Overview of operation
// - with the fuse set, the counter runs on its own oscillator tick, not the cpu clock.
// - with the fuse set software cannot stop it, and expiry resets the processor.
// - with the fuse clear it is a free interval timer whose expiry raises an interrupt.
// - a three-bit select chooses one of eight periods from 25 ms to 3.2 s.
// - with the fuse set only one control write is accepted, later ones are ignored.
// - the tick is sampled on clk_in, so a stopped cpu clock stops counting and no expiry reset follows.
// - with the fuse set, a reset from another source holds the counter inactive while it lasts.
// - a feed is a write of 1eh followed by e1h to the feed register, nothing else.
// - other instructions may run between the two feed writes.
// - a wrong sequence does nothing and the original expiry time stands.
// - an expiry reset lasts about one microsecond, then execution may start.
// - an expiry reset in power-down restarts the oscillator and waits for it to be stable.
`timescale 1ns/1ns
`default_nettype none
module wdtfs_top #(
    parameter logic [31:0] BASE_CYC = 32'(wdtfs_pkg::TMO_MIN_CYC)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // configuration and chip state
    input wire logic wd_enable_fuse_in,
    input wire logic other_reset_in,
    input wire logic power_down_in,
    // watchdog oscillator tick pin
    input wire logic wd_osc_tick_in,
    // software writes
    input wire wdtfs_pkg::wdtfs_wr_t wr_in,
    // outputs
    output logic [2:0] timeout_select_out,
    output logic interval_irq_out,
    output logic chip_reset_out,
    output logic osc_restart_out,
    output logic cpu_run_out
);
    // ---------------------------------------------------------------
    // tick synchroniser: oscillator is asynchronous to clk_in
    // ---------------------------------------------------------------
    logic tick_s1_r;
    logic tick_s2_r;
    logic tick_s3_r;
    // two flops then an edge detector on the second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_s3_r <= 1'b0;
        end else begin
            tick_s1_r <= wd_osc_tick_in;
            tick_s2_r <= tick_s1_r;
            tick_s3_r <= tick_s2_r;
        end
    end
    // own oscillator: counting advances on its tick only
    wire tick = tick_s2_r && !tick_s3_r;
    // ---------------------------------------------------------------
    // feed recogniser and control register
    // ---------------------------------------------------------------
    logic feed;
    wdtfs_feed u_feed (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .we_in(wr_in.feed_we),
        .data_in(wr_in.data),
        .feed_out(feed)
    );
    logic [2:0] sel_r;
    logic ctrl_done_r;
    // single write: locked after the first write while fuse set
    wire ctrl_ok = wr_in.ctrl_we && !(wd_enable_fuse_in && ctrl_done_r);
    // period grows by doubling from the 25 ms base up to 3.2 s
    function automatic logic [31:0] period_of(input logic [2:0] s);
        period_of = BASE_CYC << s;
    endfunction : period_of
    // eight periods from the select field
    wire [31:0] period = period_of(sel_r);
    // select and lock registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel_r <= wdtfs_pkg::SEL_RESET;
            ctrl_done_r <= 1'b0;
        end else if (ctrl_ok) begin
            sel_r <= wr_in.data[2:0];
            ctrl_done_r <= 1'b1;
        end
    end
    assign timeout_select_out = sel_r;
    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    typedef enum {WD_RUN, WD_RESET, WD_OSC_WAIT} wdtfs_state_t;
    wdtfs_state_t st_r;
    wdtfs_state_t st_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic [7:0] pcnt_r;
    logic [7:0] pcnt_nxt;
    logic irq_r;
    // hold inactive: with the fuse set, other reset sources freeze and clear the count
    wire hold = wd_enable_fuse_in && other_reset_in;
    // unstoppable: no software term gates counting when fuse set
    // cpu clock loss: tick path is synchronised on clk_in, so counting stops with it
    wire expire = tick && !hold && (st_r == WD_RUN) && (cnt_r + 32'h1 >= period);
    // feed reloads: count restarts from zero
    // wrong sequence: no feed pulse, so count continues unchanged
    assign cnt_nxt = (hold || feed || expire) ? 32'h0 : (tick ? cnt_r + 32'h1 : cnt_r);
    // reset sequencer, also used for power-down restart
    always_comb begin
        st_nxt = st_r;
        pcnt_nxt = pcnt_r;
        case (st_r)
            WD_RUN: begin
                // expiry resets the processor when enabled
                if (expire && wd_enable_fuse_in) begin
                    st_nxt = WD_RESET;
                    pcnt_nxt = 8'h0;
                end
            end
            WD_RESET: begin
                pcnt_nxt = pcnt_r + 8'h1;
                if (pcnt_r + 8'h1 >= wdtfs_pkg::RST_PULSE_CYC) begin
                    pcnt_nxt = 8'h0;
                    st_nxt = power_down_in ? WD_OSC_WAIT : WD_RUN;
                end
            end
            WD_OSC_WAIT: begin
                pcnt_nxt = pcnt_r + 8'h1;
                if (pcnt_r + 8'h1 >= wdtfs_pkg::OSC_STABLE_CYC) begin
                    st_nxt = WD_RUN;
                end
            end
            default: begin
                st_nxt = WD_RUN;
            end
        endcase
    end
    // counter, sequencer and interrupt flops
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r <= 32'h0;
            st_r <= WD_RUN;
            pcnt_r <= 8'h0;
            irq_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            st_r <= st_nxt;
            pcnt_r <= pcnt_nxt;
            // interval timer: expiry with fuse clear pulses the interrupt
            irq_r <= expire && !wd_enable_fuse_in;
        end
    end
    assign interval_irq_out = irq_r;
    assign chip_reset_out = (st_r == WD_RESET);
    assign osc_restart_out = (st_r == WD_OSC_WAIT);
    assign cpu_run_out = (st_r == WD_RUN);
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // reset pulse length seen so far; it still holds the full length in the
    // first cycle after the pulse, which is when the length check looks at it
    // a small counter keeps the check cheap instead of a long repetition
    logic [7:0] rst_len_r;
    // pulse length counter, cleared whenever the reset output is low
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_len_r <= 8'h0;
        end else if (chip_reset_out) begin
            rst_len_r <= rst_len_r + 8'h1;
        end else begin
            rst_len_r <= 8'h0;
        end
    end
    // reset pulse never outlasts the pulse count
    reset_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        chip_reset_out |-> rst_len_r < wdtfs_pkg::RST_PULSE_CYC)
        else $error("watchdog reset pulse too long");
    // a pulse that ends has run its full length
    reset_full_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(chip_reset_out) |-> rst_len_r == wdtfs_pkg::RST_PULSE_CYC)
        else $error("watchdog reset pulse too short");
    expiry_reset_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (expire && wd_enable_fuse_in) |=> chip_reset_out)
        else $error("expiry did not reset");
    // no chip reset when fuse clear
    interval_irq_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (expire && !wd_enable_fuse_in) |=> interval_irq_out && !chip_reset_out)
        else $error("interval expiry misbehaved");
    ctrl_lock_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wd_enable_fuse_in && ctrl_done_r && wr_in.ctrl_we) |=> $stable(sel_r))
        else $error("locked control changed");
    feed_reload_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        feed |=> cnt_r == 32'h0)
        else $error("feed did not reload");
    hold_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        hold |=> cnt_r == 32'h0 && !chip_reset_out || $past(st_r) != WD_RUN)
        else $error("counter ran during other reset");
    // no feed, count never falls except on expiry or hold
    count_keep_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!feed && !hold && !expire) |=> cnt_r >= $past(cnt_r))
        else $error("counter disturbed without feed");
    // count moves only on an oscillator tick, a feed or a hold
    tick_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!tick && !feed && !hold) |=> cnt_r == $past(cnt_r))
        else $error("counter moved without a tick");
    osc_wait_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (chip_reset_out && st_nxt == WD_OSC_WAIT) |=> !cpu_run_out [*8])
        else $error("resumed before oscillator stable");
    // oscillator restart only follows a watchdog reset pulse
    osc_after_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(osc_restart_out) |-> $past(chip_reset_out))
        else $error("oscillator restart without reset pulse");
endmodule : wdtfs_top
`default_nettype wire

// >>> logic/wdtfs_pkg.sv
// package of constants and types for the fed watchdog timer
package wdtfs_pkg;
    // ---------------------------------------------------------------
    // widths and keys
    // ---------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam logic [7:0] FEED_KEY1 = 8'h1e;
    localparam logic [7:0] FEED_KEY2 = 8'he1;
    localparam logic [2:0] SEL_RESET = 3'h7;
    // ---------------------------------------------------------------
    // timing: clock, timeouts, reset pulse
    // ---------------------------------------------------------------
    localparam longint CLK_HZ = 64'd10000000;
    localparam longint TMO_MIN_MS = 64'd25;
    localparam longint TMO_MIN_CYC = (TMO_MIN_MS * CLK_HZ) / 64'd1000;
    localparam longint RST_PULSE_NS = 64'd1000;
    localparam longint RST_PULSE_CYC_L = (RST_PULSE_NS * CLK_HZ + 64'd999999999) / 64'd1000000000;
    localparam logic [7:0] RST_PULSE_CYC = RST_PULSE_CYC_L[7:0];
    localparam logic [7:0] OSC_STABLE_CYC = 8'h40;
    // ---------------------------------------------------------------
    // software write port carrier
    // ---------------------------------------------------------------
    typedef struct packed {
        logic ctrl_we;
        logic feed_we;
        logic [7:0] data;
    } wdtfs_wr_t;
endpackage : wdtfs_pkg

// >>> logic/wdtfs_feed.sv
// feed key sequence recogniser
`timescale 1ns/1ns
`default_nettype none
module wdtfs_feed (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // feed register write
    input wire logic we_in,
    input wire logic [7:0] data_in,
    // one-cycle feed pulse
    output logic feed_out
);
    logic armed_r;
    logic armed_nxt;
    wire is_key1 = (data_in == wdtfs_pkg::FEED_KEY1);
    wire is_key2 = (data_in == wdtfs_pkg::FEED_KEY2);
    // ordered key pair: second key only counts after the first
    assign feed_out = we_in && armed_r && is_key2;
    // clear partial state: any other write drops the arm
    // gap allowed: arm holds while no write occurs
    assign armed_nxt = we_in ? is_key1 : armed_r;
    // arm flag register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
        end
    end
    feed_order_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        feed_out |-> $past(armed_nxt))
        else $error("feed without preceding first key");
endmodule : wdtfs_feed
`default_nettype wire

// >>> dv/wdtfs_osc_model.sv
// model of the watchdog rc oscillator driving the tick pin
`timescale 1ns/1ns
`default_nettype none
module wdtfs_osc_model #(
    parameter int HALF_NS = 400
) (
    // control
    input wire logic run_in,
    // tick pin
    output logic tick_out
);
    // own clock source
    // odd start offset keeps the tick edges off the cpu clock edges
    initial begin
        tick_out = 1'b0;
        #37;
        forever begin
            #HALF_NS;
            tick_out = run_in ? ~tick_out : 1'b0;
        end
    end
endmodule : wdtfs_osc_model
`default_nettype wire

// >>> dv/wdtfs_top_tb.sv
// self-checking bench for the fed watchdog timer
`timescale 1ns/1ns
`default_nettype none
module wdtfs_top_tb;
    // ---------------------------------------------------------------
    // bench
    // ---------------------------------------------------------------
    localparam int BASE = 16;
    localparam int TICK = 8;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic fuse = 1'b1;
    logic oth = 1'b0;
    logic pdn = 1'b0;
    logic tick;
    wdtfs_pkg::wdtfs_wr_t wr = '0;
    logic [2:0] sel;
    logic irq, crst, orst, run;
    logic [7:0] bad;
    int mismatches = 0;
    int comparisons = 0;
    int k, k0, s, crst_cyc = 0;
    longint t0;
    always #50 clk_in = ~clk_in;
    // cycles with the chip reset high, so short pulses are never missed
    always @(posedge clk_in) if (crst === 1'b1) crst_cyc++;
    wdtfs_osc_model u_osc (.run_in(1'b1), .tick_out(tick));
    wdtfs_top #(.BASE_CYC(32'(BASE))) u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .wd_enable_fuse_in(fuse), .other_reset_in(oth), .power_down_in(pdn),
        .wd_osc_tick_in(tick), .wr_in(wr), .timeout_select_out(sel),
        .interval_irq_out(irq), .chip_reset_out(crst), .osc_restart_out(orst),
        .cpu_run_out(run));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask : cyc
    task automatic wr_do(input logic c, input logic f, input logic [7:0] d);
        @(posedge clk_in);
        wr <= '{ctrl_we: c, feed_we: f, data: d};
        @(posedge clk_in);
        wr <= '0;
    endtask : wr_do
    task automatic feed(input int gap);
        wr_do(1'b0, 1'b1, wdtfs_pkg::FEED_KEY1);
        repeat (gap) @(posedge clk_in);
        wr_do(1'b0, 1'b1, wdtfs_pkg::FEED_KEY2);
    endtask : feed
    function automatic logic pick(input int w);
        return (w == 0) ? crst : (w == 1) ? irq : orst;
    endfunction : pick
    // bounded wait for one output to go high
    task automatic wait_hi(input int w);
        #1;
        k = 0;
        while (pick(w) !== 1'b1) begin
            cyc(1);
            k++;
            if (k > 3000) begin
                chk(0, 1, "wait ran out");
                report_and_stop();
            end
        end
    endtask : wait_hi
    task automatic len_hi(input int w);
        k = 0;
        while (pick(w) === 1'b1 && k < 200) begin
            cyc(1);
            k++;
        end
    endtask : len_hi
    // expiry lies one period of ticks after t0, give or take sync and tick phase
    function automatic logic [31:0] win(input int s);
        longint c;
        c = ($time - t0) / 100;
        return 32'(c >= (BASE << s) * TICK - 24 && c <= (BASE << s) * TICK + 32);
    endfunction : win
    task automatic do_reset(input logic f);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        fuse <= f;
        oth <= 1'b0;
        pdn <= 1'b0;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
    endtask : do_reset
    // the watchdog expiry scenarios share a short period setup after a feed
    task automatic arm;
        feed(1);
        wr_do(1'b1, 1'b0, 8'h00);
    endtask : arm
    initial begin
        void'($urandom(61672));
        do_reset(1'b1);
        cyc(1);
        chk(sel, 32'(wdtfs_pkg::SEL_RESET), "select at reset");
        chk(run, 1, "run at reset");
        arm();
        wr_do(1'b1, 1'b0, 8'h03);
        cyc(1);
        chk(sel, 0, "second control write taken");
        k0 = crst_cyc;
        for (int i = 0; i < 6; i++) begin
            feed($urandom_range(1, 20));
            cyc($urandom_range(20, 60));
        end
        chk(32'(crst_cyc - k0), 0, "fed watchdog expired");
        feed(2);
        t0 = $time;
        cyc(40);
        bad = 8'($urandom_range(0, 255));
        if (bad == wdtfs_pkg::FEED_KEY1 || bad == wdtfs_pkg::FEED_KEY2) bad = 8'h55;
        wr_do(1'b0, 1'b1, wdtfs_pkg::FEED_KEY1);
        wr_do(1'b0, 1'b1, bad);
        wr_do(1'b0, 1'b1, wdtfs_pkg::FEED_KEY2);
        wait_hi(0);
        chk(win(0), 1, "expiry moved by bad feed");
        chk(run, 0, "cpu runs in reset");
        len_hi(0);
        chk(k, 10, "reset pulse length");
        do_reset(1'b1);
        arm();
        oth <= 1'b1;
        k0 = crst_cyc;
        cyc(400);
        chk(32'(crst_cyc - k0), 0, "held counter expired");
        do_reset(1'b1);
        arm();
        pdn <= 1'b1;
        wait_hi(0);
        wait_hi(2);
        chk(run, 0, "run during restart");
        len_hi(2);
        chk(k, 64, "oscillator wait length");
        do_reset(1'b0);
        wr_do(1'b1, 1'b0, 8'h01);
        wr_do(1'b1, 1'b0, 8'h00);
        k0 = crst_cyc;
        wait_hi(1);
        t0 = $time;
        cyc(1);
        wait_hi(1);
        chk(win(0), 1, "interval period");
        chk(32'(crst_cyc - k0), 0, "reset in interval mode");
        // a longer period drawn at random must scale the interval by doubling
        s = $urandom_range(1, 2);
        wr_do(1'b1, 1'b0, 8'(s));
        wait_hi(1);
        t0 = $time;
        cyc(1);
        wait_hi(1);
        chk(win(s), 1, "longer interval period");
        chk(sel, 32'(s), "select rewritten with fuse clear");
        report_and_stop();
    end
endmodule : wdtfs_top_tb
`default_nettype wire
